//--- hdl/upar_pkg.sv
package upar_pkg;
    // Register addresses (6-bit immediate address field)
    localparam logic [5:0] ADDR_IFC_WR = 6'h07;
    localparam logic [5:0] ADDR_IFC_SET = 6'h08;
    localparam logic [5:0] ADDR_IFC_CLR = 6'h09;
    localparam logic [5:0] ADDR_DEBUG = 6'h15;
    localparam logic [5:0] ADDR_SCR_WR = 6'h16;
    localparam logic [5:0] ADDR_SCR_SET = 6'h17;
    localparam logic [5:0] ADDR_SCR_CLR = 6'h18;
    localparam logic [5:0] ADDR_KIT_WR = 6'h19;
    localparam logic [5:0] ADDR_KIT_SET = 6'h1A;
    localparam logic [5:0] ADDR_KIT_CLR = 6'h1B;
    localparam logic [5:0] ADDR_DRV = 6'h31;
    localparam logic [5:0] ADDR_USB = 6'h35;

    // Field positions
    localparam int IFC_KIT_MODE_BIT = 2;
    localparam int IFC_PROT_DIS_BIT = 7;
    localparam int KIT_TX_BIT = 2;
    localparam int KIT_RX_BIT = 3;
    localparam int DRV_LEVEL_LSB = 0;
    localparam int DRV_EDGE_BIT = 2;
    localparam int USB_EN_BIT = 4'h2;

    // Writable-bit masks and reset values
    localparam logic [7:0] IFC_MASK = 8'h84;
    localparam logic [7:0] KIT_MASK = 8'h0C;
    localparam logic [7:0] DRV_MASK = 8'h07;
    localparam logic [7:0] USB_MASK = 8'h04;
    localparam logic [7:0] IFC_RST = 8'h00;
    localparam logic [7:0] SCR_RST = 8'h00;
    localparam logic [7:0] KIT_RST = 8'h00;
    localparam logic [7:0] DRV_RST = 8'h00;
    localparam logic [7:0] USB_RST = 8'h00;

    // Kind of register access
    typedef enum logic [1:0] {
        UPAR_OP_NONE,
        UPAR_OP_WR,
        UPAR_OP_SET,
        UPAR_OP_CLR
    } upar_op_t;

    // One register access from the ULPI command decoder
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } upar_req_t;

    // UART pass-through pin drive
    typedef struct packed {
        logic dm_out;
        logic dm_oe;
        logic data1_out;
        logic data1_oe;
    } upar_uart_pins_t;
endpackage

//--- hdl/upar_regs.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module upar_regs (
    input wire logic i_clk, // 25 MHz ULPI clock
    input wire logic i_rst_n, // Asynchronous reset, active low
    input wire logic i_ce, // Clock enable, freezes all state when low
    input wire upar_pkg::upar_req_t i_req, // Register access from command decoder
    input wire logic i_kit_exit, // Pulse: kit UART operation has ended
    input wire logic [1:0] i_line_state, // Raw USB line state (async)
    input wire logic i_data0_pin, // ULPI data line 0 pin level (async)
    input wire logic i_dp_pin, // USB plus line level (async)
    output logic [7:0] o_rdata, // Read data
    output logic o_rd_valid, // Read data valid pulse
    output logic o_serial_kit_mode_en, // Kit UART pass-through active
    output logic o_protect_pull_en, // Interface protect pulls enabled
    output logic [1:0] o_output_drive_level, // Output drive level
    output logic o_edge_rate_sel, // 1 fast edges, 0 slow
    output logic o_usb_port_en, // USB interface enable
    output upar_pkg::upar_uart_pins_t o_uart_pins // UART pass-through pin drive
);

    //////////////////////////////////////////////////////////////////////////
    // Helpers

    // Decode a write/set/clear triple starting at base address
    function automatic upar_pkg::upar_op_t op_of(input logic [5:0] addr,
                                                  input logic [5:0] base);
        if (addr == base) begin
            op_of = upar_pkg::UPAR_OP_WR;
        end else if (addr == base + 6'h01) begin
            op_of = upar_pkg::UPAR_OP_SET;
        end else if (addr == base + 6'h02) begin
            op_of = upar_pkg::UPAR_OP_CLR;
        end else begin
            op_of = upar_pkg::UPAR_OP_NONE;
        end
    endfunction

    // Apply an access to a register, touching only its writable bits
    function automatic logic [7:0] apply(input logic [7:0] cur,
                                         input logic [7:0] wd,
                                         input upar_pkg::upar_op_t op,
                                         input logic [7:0] mask);
        logic [7:0] v;
        v = cur;
        unique case (op)
            upar_pkg::UPAR_OP_WR: v = wd;
            upar_pkg::UPAR_OP_SET: v = cur | wd;
            upar_pkg::UPAR_OP_CLR: v = cur & ~wd;
            upar_pkg::UPAR_OP_NONE: v = cur;
        endcase
        apply = (v & mask) | (cur & ~mask);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Access decode

    logic wr_en;
    upar_pkg::upar_op_t ifc_op, scr_op, kit_op;
    upar_pkg::upar_op_t drv_op, usb_op;

    // Six-bit address picks the register and the access kind
    assign wr_en = i_ce && i_req.wr;
    assign ifc_op = wr_en ? op_of(i_req.addr, upar_pkg::ADDR_IFC_WR)
                          : upar_pkg::UPAR_OP_NONE;
    assign scr_op = wr_en ? op_of(i_req.addr, upar_pkg::ADDR_SCR_WR)
                          : upar_pkg::UPAR_OP_NONE;
    assign kit_op = wr_en ? op_of(i_req.addr, upar_pkg::ADDR_KIT_WR)
                          : upar_pkg::UPAR_OP_NONE;
    // Vendor registers take plain writes only
    assign drv_op = (wr_en && i_req.addr == upar_pkg::ADDR_DRV)
                    ? upar_pkg::UPAR_OP_WR : upar_pkg::UPAR_OP_NONE;
    assign usb_op = (wr_en && i_req.addr == upar_pkg::ADDR_USB)
                    ? upar_pkg::UPAR_OP_WR : upar_pkg::UPAR_OP_NONE;

    //////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] ifc_r, scr_r, kit_r, drv_r, usb_r;
    logic [7:0] ifc_nxt;

    // Exit clears kit mode, but a link write in the same cycle wins so
    // software intent is never silently dropped
    always_comb begin
        ifc_nxt = ifc_r;
        if (i_kit_exit) begin
            ifc_nxt[upar_pkg::IFC_KIT_MODE_BIT] = 1'b0;
        end
        ifc_nxt = apply(ifc_nxt, i_req.wdata, ifc_op, upar_pkg::IFC_MASK);
    end

    // Interface control
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ifc_r <= upar_pkg::IFC_RST;
        end else if (i_ce) begin
            ifc_r <= ifc_nxt;
        end
    end

    // Scratch byte, no side effects
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scr_r <= upar_pkg::SCR_RST;
        end else if (i_ce) begin
            scr_r <= apply(scr_r, i_req.wdata, scr_op, 8'hFF);
        end
    end

    // Kit UART routing control
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            kit_r <= upar_pkg::KIT_RST;
        end else if (i_ce) begin
            kit_r <= apply(kit_r, i_req.wdata, kit_op, upar_pkg::KIT_MASK);
        end
    end

    // Vendor registers; reserved bits are not stored, so they read zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drv_r <= upar_pkg::DRV_RST;
            usb_r <= upar_pkg::USB_RST;
        end else if (i_ce) begin
            drv_r <= apply(drv_r, i_req.wdata, drv_op, upar_pkg::DRV_MASK);
            usb_r <= apply(usb_r, i_req.wdata, usb_op, upar_pkg::USB_MASK);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [3:0] pin_s1_r, pin_s2_r;

    // Two stages for every asynchronous pin input
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end else if (i_ce) begin
            pin_s1_r <= {i_dp_pin, i_data0_pin, i_line_state};
            pin_s2_r <= pin_s1_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] rd_nxt;

    // Unmapped addresses read as zero
    always_comb begin
        rd_nxt = 8'h00;
        if (op_of(i_req.addr, upar_pkg::ADDR_IFC_WR) != upar_pkg::UPAR_OP_NONE) begin
            rd_nxt = ifc_r & upar_pkg::IFC_MASK;
        end else if (op_of(i_req.addr, upar_pkg::ADDR_SCR_WR) != upar_pkg::UPAR_OP_NONE) begin
            rd_nxt = scr_r;
        end else if (op_of(i_req.addr, upar_pkg::ADDR_KIT_WR) != upar_pkg::UPAR_OP_NONE) begin
            rd_nxt = kit_r & upar_pkg::KIT_MASK;
        end else if (i_req.addr == upar_pkg::ADDR_DEBUG) begin
            rd_nxt = {6'h00, pin_s2_r[1:0]};
        end else if (i_req.addr == upar_pkg::ADDR_DRV) begin
            rd_nxt = drv_r & upar_pkg::DRV_MASK;
        end else if (i_req.addr == upar_pkg::ADDR_USB) begin
            rd_nxt = usb_r & upar_pkg::USB_MASK;
        end
    end

    // Read data registered one cycle after the request
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
            o_rd_valid <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= i_req.rd;
            if (i_req.rd) begin
                o_rdata <= rd_nxt;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Control outputs and UART routing

    logic kit_on;
    assign kit_on = ifc_r[upar_pkg::IFC_KIT_MODE_BIT];

    // Outputs follow their register bits one cycle later; UART data outputs follow the synchronised pins
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_kit_mode_en <= 1'b0;
            o_protect_pull_en <= 1'b1;
            o_output_drive_level <= 2'h0;
            o_edge_rate_sel <= 1'b0;
            o_usb_port_en <= 1'b0;
            o_uart_pins <= '0;
        end else if (i_ce) begin
            o_serial_kit_mode_en <= kit_on;
            o_protect_pull_en <= ~ifc_r[upar_pkg::IFC_PROT_DIS_BIT];
            o_output_drive_level <= drv_r[upar_pkg::DRV_LEVEL_LSB +: 2];
            o_edge_rate_sel <= drv_r[upar_pkg::DRV_EDGE_BIT];
            o_usb_port_en <= usb_r[upar_pkg::USB_EN_BIT];
            // Routing bits are dead unless kit mode is on
            o_uart_pins.dm_oe <= kit_on & kit_r[upar_pkg::KIT_TX_BIT];
            o_uart_pins.dm_out <= pin_s2_r[2];
            o_uart_pins.data1_oe <= kit_on & kit_r[upar_pkg::KIT_RX_BIT];
            o_uart_pins.data1_out <= pin_s2_r[3];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions

    a_scratch_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.wr && i_req.addr == upar_pkg::ADDR_SCR_WR
        |=> scr_r == $past(i_req.wdata))
        else $error("scratch write not stored");

    a_scratch_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.wr && i_req.addr == upar_pkg::ADDR_SCR_SET
        |=> scr_r == ($past(scr_r) | $past(i_req.wdata)))
        else $error("scratch set wrong");

    a_scratch_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.wr && i_req.addr == upar_pkg::ADDR_SCR_CLR
        |=> scr_r == ($past(scr_r) & ~$past(i_req.wdata)))
        else $error("scratch clear wrong");

    a_kit_mode_exit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_kit_exit && ifc_op == upar_pkg::UPAR_OP_NONE
        |=> !ifc_r[upar_pkg::IFC_KIT_MODE_BIT])
        else $error("kit mode not cleared on exit");

    a_route_gated: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !kit_on |=> !o_uart_pins.dm_oe && !o_uart_pins.data1_oe)
        else $error("routing active outside kit mode");

    a_debug_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.rd && i_req.addr == upar_pkg::ADDR_DEBUG
        |=> o_rd_valid && o_rdata == {6'h00, $past(pin_s2_r[1:0])})
        else $error("debug read wrong");

    a_usb_reserved: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.rd && i_req.addr == upar_pkg::ADDR_USB
        |=> o_rdata[1:0] == 2'h0 && o_rdata[7:3] == 5'h00)
        else $error("usb reserved bits not zero");

    a_drive_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.wr && i_req.addr == upar_pkg::ADDR_DRV ##1 i_ce
        |=> o_output_drive_level == $past(i_req.wdata[1:0], 2))
        else $error("drive level not applied");

    a_protect_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce |=> o_protect_pull_en == !$past(ifc_r[upar_pkg::IFC_PROT_DIS_BIT]))
        else $error("protect pulls wrong");

    a_usb_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.wr && i_req.addr == upar_pkg::ADDR_USB ##1 i_ce
        |=> o_usb_port_en == $past(i_req.wdata[2], 2))
        else $error("usb enable not applied");

    a_ifc_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.wr && i_req.addr == upar_pkg::ADDR_IFC_WR
        |=> (ifc_r & upar_pkg::IFC_MASK) == ($past(i_req.wdata) & upar_pkg::IFC_MASK))
        else $error("interface control write not stored");

    a_ifc_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.rd && i_req.addr >= upar_pkg::ADDR_IFC_WR
        && i_req.addr <= upar_pkg::ADDR_IFC_CLR
        |=> o_rd_valid && o_rdata == ($past(ifc_r) & upar_pkg::IFC_MASK))
        else $error("interface control read wrong");

    a_kit_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.wr && i_req.addr == upar_pkg::ADDR_KIT_SET
        |=> (kit_r & upar_pkg::KIT_MASK)
            == (($past(kit_r) | $past(i_req.wdata)) & upar_pkg::KIT_MASK))
        else $error("kit control set wrong");

    a_tx_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && kit_on && kit_r[upar_pkg::KIT_TX_BIT]
        |=> o_uart_pins.dm_oe && o_uart_pins.dm_out == $past(pin_s2_r[2]))
        else $error("transmit route wrong");

    a_rx_route: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && kit_on && kit_r[upar_pkg::KIT_RX_BIT]
        |=> o_uart_pins.data1_oe && o_uart_pins.data1_out == $past(pin_s2_r[3]))
        else $error("receive route wrong");

    a_edge_rate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_req.wr && i_req.addr == upar_pkg::ADDR_DRV ##1 i_ce
        |=> o_edge_rate_sel == $past(i_req.wdata[upar_pkg::DRV_EDGE_BIT], 2))
        else $error("edge rate not applied");

endmodule

//--- bench/upar_link.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Link controller model: register accesses and the link-side data line 0
module upar_link (
    input wire logic i_clk, // Register clock
    input wire logic i_rd_valid, // Read answer strobe
    input wire logic [7:0] i_rdata, // Read answer byte
    output upar_pkg::upar_req_t o_req, // Register access
    output logic o_data0 // Data line 0, UART transmit source
);
    // Idle bus at time zero
    initial begin
        o_req = '0;
        o_data0 = 1'b0;
    end
    // Held from a falling edge through the taking edge; the idle bus is scrambled
    // afterwards so a design that samples late sees garbage, not the old value
    task automatic access(input logic is_rd, input logic [5:0] a, input logic [7:0] d);
        @(negedge i_clk);
        if (a == upar_pkg::ADDR_USB) begin
            d = d & upar_pkg::USB_MASK;
        end
        o_req = {is_rd, !is_rd, a, d};
        @(posedge i_clk);
        @(negedge i_clk);
        o_req = {1'b0, 1'b0, ~a, ~d};
    endtask
    // The answer stands only from the taking edge to the next one, so it is
    // picked up at the falling edge in between, where access returns
    task automatic rd(input logic [5:0] a, output logic [7:0] q, output logic v);
        access(1'b1, a, 8'h00);
        q = i_rdata;
        v = i_rd_valid;
    endtask
    // Data line 0 changes only after a falling edge
    task automatic pin(input logic b);
        @(negedge i_clk);
        o_data0 = b;
    endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the auxiliary register bank
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic kit_exit = 1'b0;
    logic [1:0] line_state = 2'b00;
    logic dp = 1'b0;
    upar_pkg::upar_req_t req;
    upar_pkg::upar_uart_pins_t pins;
    logic data0;
    logic [7:0] rdata;
    logic rd_valid;
    logic kit_mode;
    logic pull_en;
    logic edge_sel;
    logic usb_en;
    logic [1:0] drv;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    // Clock enable held high except in the freeze scenario
    upar_regs dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_req(req),
        .i_kit_exit(kit_exit), .i_line_state(line_state), .i_data0_pin(data0),
        .i_dp_pin(dp), .o_rdata(rdata), .o_rd_valid(rd_valid),
        .o_serial_kit_mode_en(kit_mode), .o_protect_pull_en(pull_en),
        .o_output_drive_level(drv), .o_edge_rate_sel(edge_sel),
        .o_usb_port_en(usb_en), .o_uart_pins(pins));
    upar_link link (.i_clk(clk), .i_rd_valid(rd_valid), .i_rdata(rdata),
        .o_req(req), .o_data0(data0));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and shared helpers
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            end_sim();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic v;
        link.rd(a, q, v);
        chk({7'h00, v}, 8'h01);
        chk(q, exp);
    endtask
    // Control outputs follow two edges after a write
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        link.access(1'b0, a, d);
        repeat (2) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        chk({4'h0, kit_mode, pull_en, edge_sel, usb_en}, 8'h04);
        chk({2'h0, drv, pins}, 8'h00);
        rchk(6'h07, 8'h00);
        rchk(6'h16, 8'h00);
        rchk(6'h19, 8'h00);
        rchk(6'h31, 8'h00);
        rchk(6'h35, 8'h00);
        $display("reset values done");
    endtask
    task automatic t_ifc;
        wr(6'h07, 8'hFF);
        chk({6'h00, kit_mode, pull_en}, 8'h02);
        rchk(6'h08, 8'h84);
        wr(6'h09, 8'h80);
        rchk(6'h09, 8'h04);
        @(negedge clk) kit_exit = 1'b1;
        @(negedge clk) kit_exit = 1'b0;
        @(negedge clk);
        chk({7'h00, kit_mode}, 8'h00);
        wr(6'h08, 8'h80);
        rchk(6'h07, 8'h80);
        $display("interface control done");
    endtask
    task automatic t_scratch;
        wr(6'h16, 8'hA5);
        wr(6'h17, 8'h5A);
        rchk(6'h16, 8'hFF);
        wr(6'h18, 8'h0F);
        rchk(6'h17, 8'hF0);
        rchk(6'h18, 8'hF0);
        $display("scratch done");
    endtask
    task automatic t_uart;
        wr(6'h19, 8'hFF);
        rchk(6'h1A, 8'h0C);
        chk({6'h00, pins.dm_oe, pins.data1_oe}, 8'h00);
        wr(6'h08, 8'h04);
        chk({6'h00, pins.dm_oe, pins.data1_oe}, 8'h03);
        // Start at one so a stuck-low path cannot match
        for (int b = 1; b >= 0; b--) begin
            link.pin(b[0]);
            dp = b[0];
            repeat (4) @(negedge clk);
            chk({6'h00, pins.dm_out, pins.data1_out}, {6'h00, b[0], b[0]});
        end
        wr(6'h1B, 8'h04);
        rchk(6'h19, 8'h08);
        chk({6'h00, pins.dm_oe, pins.data1_oe}, 8'h01);
        wr(6'h1A, 8'h04);
        rchk(6'h1B, 8'h0C);
        wr(6'h09, 8'h04);
        chk({6'h00, pins.dm_oe, pins.data1_oe}, 8'h00);
        $display("kit uart done");
    endtask
    task automatic t_vendor;
        for (int lv = 0; lv < 8; lv++) begin
            wr(6'h31, 8'hF8 | lv[7:0]);
            chk({5'h00, edge_sel, drv}, lv[7:0]);
            rchk(6'h31, lv[7:0]);
        end
        wr(6'h35, 8'hFF);
        rchk(6'h35, 8'h04);
        chk({7'h00, usb_en}, 8'h01);
        rchk(6'h3F, 8'h00);
        wr(6'h15, 8'hFF);
        for (int ls = 1; ls < 4; ls++) begin
            line_state = ls[1:0];
            repeat (3) @(negedge clk);
            rchk(6'h15, ls[7:0]);
        end
        $display("vendor and debug done");
    endtask
    // A write taken while the clock enable is low must leave no trace
    task automatic t_freeze;
        @(negedge clk) ce = 1'b0;
        link.access(1'b0, 6'h16, 8'h3C);
        @(negedge clk) ce = 1'b1;
        rchk(6'h16, 8'hF0);
        $display("clock enable freeze done");
    endtask

    // Reset for 8 cycles, every scenario in turn, then a mid-run reset
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_ifc();
        t_scratch();
        t_uart();
        t_vendor();
        t_freeze();
        @(negedge clk) rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        end_sim();
    end
endmodule
